// ===== hdl/rfft_top.sv
// Radix-2 FFT coprocessor: operand port, pass control, registers
// What this block does
// - Transforms of 8 to 1024 points
// - Radix-2 DIT, bit-reversed result order
// - Operands only from the read buses
// - Holds on stall, drops failed conditions
// - One butterfly, first results fed back
// - Single-stage mode for the odd stage
// - Multiply stage, then add/subtract stage
// - Single-stage first output after five cycles
// - Double-stage first output after nine cycles
// - Prologue, kernel and epilogue per pass
// - Next pass may overlap current one
// - Internal 512-entry 16-bit complex table
// - Decimated, stage-driven twiddle index, registered only in single-stage mode
// - Conjugate twiddles for inverse transform
// - Scaled mode halves outputs with rounding
// - Unscaled mode bypasses the scaling
// - Parts are signed Q15 values
// - Real upper half, imaginary lower
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module rfft_top (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [rfft_pkg::CW-1:0]   hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [rfft_pkg::CW-1:0]        hrdata,
  output logic                           hresp,
  input  wire logic                      cpu_stall,
  input  wire logic                      op_valid,
  input  wire logic                      op_cond_ok,
  input  wire logic [1:0]                op_bus_sel,
  input  wire logic [rfft_pkg::CW-1:0]   rd_bus_b,
  input  wire logic [rfft_pkg::CW-1:0]   rd_bus_c,
  input  wire logic [rfft_pkg::CW-1:0]   rd_bus_d,
  output logic                           res_valid,
  output logic [rfft_pkg::CW-1:0]        res_data
);
  import rfft_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic                  ifft;
    logic                  unsc;
    logic                  dbl;
    logic [3:0]            len;
    logic [3:0]            stg;
    logic                  bad;
    logic                  wr_pend;
    logic [AW-1:0]         wr_addr;
    logic [CW-1:0]         rdata;
    logic                  rdy;
    logic                  resp;
    logic                  in_v;
    rfft_cplx_s            in_d;
    rfft_cplx_s            hold;
    logic [1:0]            ph;
    logic [CNT_W-1:0]      bcnt;
    logic                  iss_v;
    rfft_cplx_s            iss_p;
    rfft_cplx_s            iss_q;
    logic [TW_AW-1:0]      iss_t;
    logic                  bank;
    rfft_cplx_s [1:0][3:0] store;
    logic [1:0][CNT_W-1:0] kreg;
    rfft_fb_e              fb;
    logic                  fb_bank;
    logic                  ov;
    rfft_cplx_s            od;
    logic                  qp;
    rfft_cplx_s            qd;
    logic [15:0]           rcnt;
  } rfft_top_s;

  // Registered state and its next value
  rfft_top_s        s;
  rfft_top_s        next_s;
  logic             pair_now;
  logic             a_ok;
  logic             busy;
  logic [TW_AW-1:0] sel_t;
  logic [4:0]       need;

  rfft_bfly_if bf ();

  // ==========================================================
  // Twiddle index: k masked to stage span, stride 512 >> stage
  function automatic logic [TW_AW-1:0] rfft_tidx(input logic [CNT_W-1:0] k,
                                                 input logic [3:0] st);
    logic [CNT_W-1:0]   m;
    logic [2*CNT_W-1:0] t;
    m = (CNT_W'(1) << st) - CNT_W'(1);
    t = {{CNT_W{1'b0}}, k & m} << (4'(TW_AW) - st);
    return t[TW_AW-1:0];
  endfunction

  // Second member of a pair is on the input register
  assign pair_now = s.in_v & s.ph[0];

  // Anything still in flight counts as busy
  assign busy = s.in_v | s.iss_v | bf.busy | s.qp | s.ov | (s.fb != FB_IDLE);

  // ==========================================================
  // Butterfly feed: input pairs first, fed-back pairs in free slots
  always_comb begin
    bf.v    = 1'b0;
    bf.p    = s.iss_p;
    bf.q    = s.iss_q;
    bf.unsc = s.unsc;
    bf.dst  = DST_OUT;
    bf.bank = s.bank;
    bf.hold = cpu_stall;
    sel_t   = s.iss_t;
    // Input pairs win over fed-back pairs
    if (!s.dbl) begin
      bf.v = s.iss_v;
    end else if (pair_now) begin
      bf.v   = 1'b1;
      bf.p   = s.hold;
      bf.q   = s.in_d;
      bf.dst = s.ph[1] ? DST_FB_HI : DST_FB_LO;
      sel_t  = rfft_tidx(s.bcnt >> 1, s.stg);
    end else if (s.fb == FB_ISSUE_C || s.fb == FB_ISSUE_D) begin
      bf.v    = 1'b1;
      bf.bank = s.fb_bank;
      if (s.fb == FB_ISSUE_C) begin
        bf.p  = s.store[s.fb_bank][0];
        bf.q  = s.store[s.fb_bank][2];
        sel_t = rfft_tidx(s.kreg[s.fb_bank], s.stg + 4'h1);
      end else begin
        bf.p  = s.store[s.fb_bank][1];
        bf.q  = s.store[s.fb_bank][3];
        sel_t = rfft_tidx(s.kreg[s.fb_bank] + CNT_W'(1), s.stg + 4'h1);
      end
    end
  end

  // Internal table, conjugated in inverse mode
  rfft_twiddle u_twiddle (
    .idx  (sel_t),
    .conj (s.ifft),
    .w    (bf.w)
  );

  // One butterfly serves both stages
  rfft_bfly u_bfly (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bf      (bf)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    a_ok   = hsel & htrans[1] & hready;
    need   = 5'({1'b0, hwdata[CTRL_STG +: 4]}) + (hwdata[CTRL_DBL] ? 5'h02 : 5'h01);

    // Whole datapath freezes while the core stalls
    if (!cpu_stall) begin
      // Operand from one of the three read buses
      next_s.in_v = op_valid & op_cond_ok & ~s.bad;
      unique case (op_bus_sel)
        SEL_C:   next_s.in_d = rd_bus_c;
        SEL_D:   next_s.in_d = rd_bus_d;
        default: next_s.in_d = rd_bus_b;
      endcase

      // Prologue: collect one complex input at a time
      if (s.in_v) begin
        next_s.hold = s.in_d;
        next_s.ph   = s.ph + 2'h1;
        if (s.ph[0]) begin
          next_s.bcnt = s.bcnt + CNT_W'(1);
        end
      end

      // Single-stage issue register and its twiddle index
      next_s.iss_v = pair_now & ~s.dbl;
      next_s.iss_p = s.hold;
      next_s.iss_q = s.in_d;
      next_s.iss_t = rfft_tidx(s.bcnt, s.stg);

      // Second pair of a group closes the bank
      if (pair_now && s.dbl && s.ph[1]) begin
        next_s.bank         = ~s.bank;
        next_s.kreg[s.bank] = s.bcnt & ~CNT_W'(1);
      end

      // Feedback sequencing, waits on input pairs
      unique case (s.fb)
        FB_IDLE:    next_s.fb = FB_IDLE;
        FB_ISSUE_C: if (!pair_now) next_s.fb = FB_GAP;
        FB_GAP:     next_s.fb = FB_ISSUE_D;
        FB_ISSUE_D: if (!pair_now) next_s.fb = FB_IDLE;
      endcase

      // First-stage results go back to the store
      if (bf.o_v) begin
        unique case (bf.o_dst)
          DST_FB_LO: begin
            next_s.store[bf.o_bank][0] = bf.o_p;
            next_s.store[bf.o_bank][1] = bf.o_q;
          end
          DST_FB_HI: begin
            next_s.store[bf.o_bank][2] = bf.o_p;
            next_s.store[bf.o_bank][3] = bf.o_q;
            next_s.fb                  = FB_ISSUE_C;
            next_s.fb_bank             = bf.o_bank;
          end
          default: next_s.fb = next_s.fb;
        endcase
      end

      // Kernel and epilogue: upper output, then lower
      if (bf.o_v && bf.o_dst == DST_OUT) begin
        next_s.ov = 1'b1;
        next_s.od = bf.o_p;
        next_s.qp = 1'b1;
        next_s.qd = bf.o_q;
      end else if (s.qp) begin
        next_s.ov = 1'b1;
        next_s.od = s.qd;
        next_s.qp = 1'b0;
      end else begin
        next_s.ov = 1'b0;
      end
      // Result counter for the status register
      if (next_s.ov) begin
        next_s.rcnt = s.rcnt + 16'h0001;
      end
    end

    // ==========================================================
    // Register slave, zero wait states, always OKAY
    if (s.wr_pend && s.wr_addr == CTRL_OFF) begin
      next_s.ifft = hwdata[CTRL_IFFT];
      next_s.unsc = hwdata[CTRL_UNSC];
      next_s.dbl  = hwdata[CTRL_DBL];
      next_s.len  = hwdata[CTRL_LEN +: 4];
      next_s.stg  = hwdata[CTRL_STG +: 4];
      next_s.bad  = (hwdata[CTRL_LEN +: 4] < LOG2_MIN) ||
                    (hwdata[CTRL_LEN +: 4] > LOG2_MAX) ||
                    (need > {1'b0, hwdata[CTRL_LEN +: 4]});
      // New pass restarts counting, pipeline drains on
      next_s.ph   = 2'h0;
      next_s.bcnt = '0;
    end
    // Write data follows its address by one cycle
    next_s.wr_pend = a_ok & hwrite;
    if (a_ok) begin
      next_s.wr_addr = haddr[AW-1:0];
    end
    // Read data loads at the address edge; beside a CTRL write it is the old value
    if (a_ok && !hwrite) begin
      next_s.rdata = '0;
      unique case (haddr[AW-1:0])
        CTRL_OFF: begin
          next_s.rdata[CTRL_IFFT]     = s.ifft;
          next_s.rdata[CTRL_UNSC]     = s.unsc;
          next_s.rdata[CTRL_DBL]      = s.dbl;
          next_s.rdata[CTRL_LEN +: 4] = s.len;
          next_s.rdata[CTRL_STG +: 4] = s.stg;
        end
        STAT_OFF: begin
          next_s.rdata[STAT_BUSY]      = busy;
          next_s.rdata[STAT_BAD]       = s.bad;
          next_s.rdata[STAT_CNT +: 16] = s.rcnt;
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s     <= '0;
      s.len <= LEN_RST;
      s.rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign hreadyout = s.rdy;
  assign hrdata    = s.rdata;
  assign hresp     = s.resp;
  assign res_valid = s.ov;
  assign res_data  = s.od;
endmodule

// ===== shared/rfft_pkg.sv
// Shared constants and types for the radix-2 FFT coprocessor
package rfft_pkg;
  // ==========================================================
  // Data and table geometry
  localparam int         DW        = 16;
  localparam int         CW        = 32;
  localparam int         TW_DEPTH  = 512;
  localparam int         TW_AW     = 9;
  localparam int         TW_ONE    = 32767;
  localparam real        RFFT_PI   = 3.14159265358979;
  localparam int         CNT_W     = 10;
  localparam logic [3:0] LOG2_MIN  = 4'h3;
  localparam logic [3:0] LOG2_MAX  = 4'hA;
  // ==========================================================
  // Latency figures, first input read to first output
  localparam int         LAT_SINGLE = 5;
  localparam int         LAT_DOUBLE = 9;
  // ==========================================================
  // Rounding and shift for the two scale modes
  localparam logic signed [34:0] RND_SCALED = 35'sh0_0000_8000;
  localparam logic signed [34:0] RND_UNSC   = 35'sh0_0000_4000;
  localparam int         SH_SCALED = 16;
  localparam int         SH_UNSC   = 15;
  // ==========================================================
  // Register map and fields
  localparam int         AW        = 8;
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] STAT_OFF  = 8'h04;
  localparam int         CTRL_IFFT = 0;
  localparam int         CTRL_UNSC = 1;
  localparam int         CTRL_DBL  = 2;
  localparam int         CTRL_LEN  = 4;
  localparam int         CTRL_STG  = 8;
  localparam logic [3:0] LEN_RST   = 4'hA;
  localparam int         STAT_BUSY = 0;
  localparam int         STAT_BAD  = 1;
  localparam int         STAT_CNT  = 16;
  // ==========================================================
  // Read bus select codes
  localparam logic [1:0] SEL_C     = 2'h1;
  localparam logic [1:0] SEL_D     = 2'h2;

  // Real part upper half, imaginary lower half
  typedef struct packed {
    logic signed [DW-1:0] re;
    logic signed [DW-1:0] im;
  } rfft_cplx_s;

  typedef enum logic [1:0] {DST_OUT, DST_FB_LO, DST_FB_HI} rfft_dst_e;
  typedef enum logic [1:0] {FB_IDLE, FB_ISSUE_C, FB_GAP, FB_ISSUE_D} rfft_fb_e;
endpackage

// ===== shared/rfft_bfly_if.sv
// Operand and result bundle between the control and the butterfly
`timescale 1ns/1ps
interface rfft_bfly_if;
  import rfft_pkg::*;
  logic       v;
  rfft_cplx_s p;
  rfft_cplx_s q;
  rfft_cplx_s w;
  logic       unsc;
  rfft_dst_e  dst;
  logic       bank;
  logic       hold;
  logic       o_v;
  rfft_cplx_s o_p;
  rfft_cplx_s o_q;
  rfft_dst_e  o_dst;
  logic       o_bank;
  logic       busy;
  modport core (input v, p, q, w, unsc, dst, bank, hold,
                output o_v, o_p, o_q, o_dst, o_bank, busy);
  modport user (output v, p, q, unsc, dst, bank, hold,
                input w, o_v, o_p, o_q, o_dst, o_bank, busy);
endinterface

// ===== hdl/rfft_twiddle.sv
// Twiddle factor table with conjugation
`timescale 1ns/1ps
module rfft_twiddle (
  input  wire logic [rfft_pkg::TW_AW-1:0] idx,
  input  wire logic                       conj,
  output rfft_pkg::rfft_cplx_s            w
);
  import rfft_pkg::*;
  typedef logic [TW_DEPTH-1:0][CW-1:0] rfft_tab_t;

  // Builds cos/-sin of 2*pi*k/1024 in Q15
  function automatic rfft_tab_t rfft_build();
    rfft_tab_t t;
    real       a;
    int        re;
    int        im;
    t = '0;
    for (int k = 0; k < TW_DEPTH; k++) begin
      a    = RFFT_PI * k / TW_DEPTH;
      re   = $rtoi($floor($cos(a) * TW_ONE + 0.5));
      im   = $rtoi($floor(-$sin(a) * TW_ONE + 0.5));
      t[k] = {re[15:0], im[15:0]};
    end
    return t;
  endfunction

  localparam rfft_tab_t TAB = rfft_build();

  // Lookup, conjugate for inverse
  always_comb begin
    w = TAB[idx];
    if (conj) begin
      w.im = -w.im;
    end
  end
endmodule

// ===== hdl/rfft_bfly.sv
// Two-stage pipelined radix-2 DIT butterfly
`timescale 1ns/1ps
module rfft_bfly (
  input  wire logic hclk,
  input  wire logic hresetn,
  rfft_bfly_if.core bf
);
  import rfft_pkg::*;
  typedef struct packed {
    logic              v1;
    rfft_cplx_s        p1;
    logic signed [32:0] mr;
    logic signed [32:0] mi;
    logic              u1;
    rfft_dst_e         d1;
    logic              b1;
    logic              v2;
    rfft_cplx_s        p2;
    rfft_cplx_s        q2;
    rfft_dst_e         d2;
    logic              b2;
  } rfft_bfly_s;
  rfft_bfly_s s;
  rfft_bfly_s next_s;

  // Add or subtract product, then round and narrow
  function automatic logic signed [DW-1:0] rfft_fold(input logic signed [DW-1:0] p,
                                                     input logic signed [32:0] m,
                                                     input logic u,
                                                     input logic neg);
    logic signed [34:0] t;
    t = {{4{p[DW-1]}}, p, 15'h0000};
    t = neg ? t - 35'(m) : t + 35'(m);
    if (u) begin
      t = (t + RND_UNSC) >>> SH_UNSC;
    end else begin
      t = (t + RND_SCALED) >>> SH_SCALED;
    end
    return t[DW-1:0];
  endfunction

  // Multiply stage, then add/subtract stage
  always_comb begin
    next_s = s;
    if (!bf.hold) begin
      next_s.v1 = bf.v;
      next_s.p1 = bf.p;
      next_s.u1 = bf.unsc;
      next_s.d1 = bf.dst;
      next_s.b1 = bf.bank;
      next_s.mr = 33'(bf.q.re * bf.w.re) - 33'(bf.q.im * bf.w.im);
      next_s.mi = 33'(bf.q.re * bf.w.im) + 33'(bf.q.im * bf.w.re);
      next_s.v2 = s.v1;
      next_s.d2 = s.d1;
      next_s.b2 = s.b1;
      next_s.p2.re = rfft_fold(s.p1.re, s.mr, s.u1, 1'b0);
      next_s.p2.im = rfft_fold(s.p1.im, s.mi, s.u1, 1'b0);
      next_s.q2.re = rfft_fold(s.p1.re, s.mr, s.u1, 1'b1);
      next_s.q2.im = rfft_fold(s.p1.im, s.mi, s.u1, 1'b1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Result side
  assign bf.o_v    = s.v2;
  assign bf.o_p    = s.p2;
  assign bf.o_q    = s.q2;
  assign bf.o_dst  = s.d2;
  assign bf.o_bank = s.b2;
  assign bf.busy   = s.v1 | s.v2;
endmodule

// ===== verification/rfft_cpu_model.sv
// Host core model: drives operands onto the three read buses
`timescale 1ns/1ps
module rfft_cpu_model
  import rfft_pkg::*;
(
  input  wire logic               hclk,
  output logic                    cpu_stall,
  output logic                    op_valid,
  output logic                    op_cond_ok,
  output logic [1:0]              op_bus_sel,
  output logic [rfft_pkg::CW-1:0] rd_bus_b,
  output logic [rfft_pkg::CW-1:0] rd_bus_c,
  output logic [rfft_pkg::CW-1:0] rd_bus_d
);
  // ==========================================================
  // Idle at time zero
  initial begin
    cpu_stall  = 1'b0;
    op_valid   = 1'b0;
    op_cond_ok = 1'b0;
    op_bus_sel = 2'h0;
    rd_bus_b   = 32'h0;
    rd_bus_c   = 32'h0;
    rd_bus_d   = 32'h0;
  end
  // ==========================================================
  // One core cycle; buses that carry no operand show inverted junk
  task automatic cycle(input logic v, input logic c, input logic [1:0] s, input logic [CW-1:0] x,
                       input logic st);
    @(posedge hclk);
    op_valid   <= v;
    op_cond_ok <= c;
    op_bus_sel <= s;
    cpu_stall  <= st;
    rd_bus_b   <= (v && s != SEL_C && s != SEL_D) ? x : ~rd_bus_b;
    rd_bus_c   <= (v && s == SEL_C) ? x : ~rd_bus_c;
    rd_bus_d   <= (v && s == SEL_D) ? x : ~rd_bus_d;
  endtask
endmodule

// ===== verification/rfft_top_props.sv
// Port-level properties of the FFT coprocessor
`timescale 1ns/1ps
module rfft_top_props
  import rfft_pkg::*;
(
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic [rfft_pkg::CW-1:0] hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic [rfft_pkg::CW-1:0] hrdata,
  input wire logic                    hresp,
  input wire logic                    cpu_stall,
  input wire logic                    op_valid,
  input wire logic                    op_cond_ok,
  input wire logic [1:0]              op_bus_sel,
  input wire logic [rfft_pkg::CW-1:0] rd_bus_b,
  input wire logic [rfft_pkg::CW-1:0] rd_bus_c,
  input wire logic [rfft_pkg::CW-1:0] rd_bus_d,
  input wire logic                    res_valid,
  input wire logic [rfft_pkg::CW-1:0] res_data
);
  logic        wp;
  logic [31:0] ctl;
  logic        fresh;
  logic [3:0]  quiet;
  logic        take;
  logic        bad;
  logic        rd_sel;
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Shadow of the control word, operand acceptance, idle count
  assign bad    = ctl[7:4] < LOG2_MIN || ctl[7:4] > LOG2_MAX ||
                  ({1'b0, ctl[11:8]} + (ctl[CTRL_DBL] ? 5'h02 : 5'h01)) > {1'b0, ctl[7:4]};
  assign take   = op_valid && op_cond_ok && !cpu_stall && !bad;
  assign rd_sel = hsel && htrans[1] && hready && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp    <= 1'b0;
      ctl   <= {24'h0, LEN_RST, 4'h0};
      fresh <= 1'b0;
      quiet <= 4'hF;
    end else begin
      wp <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == CTRL_OFF;
      if (wp) ctl <= hwdata;
      if (take) fresh <= 1'b0;
      else if (wp) fresh <= 1'b1;
      if (take) quiet <= 4'h0;
      else if (!cpu_stall && quiet != 4'hF) quiet <= quiet + 4'h1;
    end
  end
  // ==========================================================
  // Properties
  property p_bus_ok;
    hsel && htrans[1] |=> hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error response");
  property p_unmapped;
    rd_sel && haddr[7:0] == 8'h08 |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_rd;
    rd_sel && haddr[7:0] == CTRL_OFF |=> hrdata == $past(ctl);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read-back wrong");
  property p_stall_hold;
    cpu_stall |=> $stable(res_valid) && $stable(res_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("result moved during stall");
  property p_lat_single;
    fresh && quiet == 4'hF && take && !ctl[CTRL_DBL] ##1 take ##0 (!cpu_stall) [*6]
      |-> res_valid && !$past(res_valid);
  endproperty
  a_lat_single: assert property (p_lat_single) else $error("single-stage latency wrong");
  property p_lat_double;
    fresh && quiet == 4'hF && take && ctl[CTRL_DBL] ##1 take [*3] ##0 (!cpu_stall) [*8]
      |-> res_valid && !$past(res_valid);
  endproperty
  a_lat_double: assert property (p_lat_double) else $error("double-stage latency wrong");
  property p_flush;
    quiet == 4'hF |-> !res_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("result without pending operands");
  property p_pair;
    $rose(res_valid) |=> res_valid;
  endproperty
  a_pair: assert property (p_pair) else $error("butterfly output not paired");
  c_single: cover property (take && !ctl[CTRL_DBL]);
  c_double: cover property ($rose(res_valid) && ctl[CTRL_DBL]);
  c_stall: cover property (cpu_stall && res_valid);
endmodule
bind rfft_top rfft_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .cpu_stall(cpu_stall), .op_valid(op_valid), .op_cond_ok(op_cond_ok),
  .op_bus_sel(op_bus_sel), .rd_bus_b(rd_bus_b), .rd_bus_c(rd_bus_c), .rd_bus_d(rd_bus_d),
  .res_valid(res_valid), .res_data(res_data));

// ===== verification/rfft_top_bench.sv
// Self-checking bench: register bus, operand streams, butterfly results
`timescale 1ns/1ps
module rfft_top_bench;
  import rfft_pkg::*;
  // ==========================================================
  // Signals and bookkeeping
  logic          hclk;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [2:0]    hsize = 3'h2;
  logic [CW-1:0] hwdata = 32'h0;
  logic          hreadyout;
  logic [CW-1:0] hrdata;
  logic          hresp;
  logic          cpu_stall;
  logic          op_valid;
  logic          op_cond_ok;
  logic [1:0]    op_bus_sel;
  logic [CW-1:0] rd_bus_b;
  logic [CW-1:0] rd_bus_c;
  logic [CW-1:0] rd_bus_d;
  logic          res_valid;
  logic [CW-1:0] res_data;
  logic [CW-1:0] rd;
  logic [CW-1:0] got[$];
  logic [CW-1:0] exp_q[$];
  int            mismatches = 0;
  int            checked = 0;
  int            seed = 55;
  int            total = 0;
  rfft_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cpu_stall(cpu_stall), .op_valid(op_valid), .op_cond_ok(op_cond_ok), .op_bus_sel(op_bus_sel),
    .rd_bus_b(rd_bus_b), .rd_bus_c(rd_bus_c), .rd_bus_d(rd_bus_d), .res_valid(res_valid), .res_data(res_data));
  rfft_cpu_model CPU (.hclk(hclk), .cpu_stall(cpu_stall), .op_valid(op_valid), .op_cond_ok(op_cond_ok),
    .op_bus_sel(op_bus_sel), .rd_bus_b(rd_bus_b), .rd_bus_c(rd_bus_c), .rd_bus_d(rd_bus_d));
  // ==========================================================
  // Clock and result collector (a stalled result counts once)
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (hresetn === 1'b1 && res_valid === 1'b1 && cpu_stall === 1'b0) got.push_back(res_data);
  end
  // ==========================================================
  // Reference arithmetic: scaled rounds the Q30 sum, unscaled rounds the signed product and wraps
  function automatic rfft_cplx_s bf(input rfft_cplx_s p, input rfft_cplx_s q, input rfft_cplx_s w,
                                    input logic u, input logic sub);
    longint     mr;
    longint     mi;
    rfft_cplx_s r;
    mr = longint'(q.re) * w.re - longint'(q.im) * w.im;
    mi = longint'(q.re) * w.im + longint'(q.im) * w.re;
    if (sub) begin
      mr = -mr;
      mi = -mi;
    end
    if (u) begin
      mr = (mr + 16384) >>> 15;
      mi = (mi + 16384) >>> 15;
    end
    if (u) begin
      r.re = p.re + 16'(mr);
      r.im = p.im + 16'(mi);
    end else begin
      r.re = 16'(((longint'(p.re) <<< 15) + mr + 32768) >>> 16);
      r.im = 16'(((longint'(p.im) <<< 15) + mi + 32768) >>> 16);
    end
    return r;
  endfunction
  // Twiddle at 0 or 90 degrees, conjugated for the inverse
  function automatic rfft_cplx_s tw(input int idx, input logic inv);
    tw.re = (idx == 0) ? 16'sh7FFF : 16'sh0000;
    tw.im = (idx == 0) ? 16'sh0000 : (inv ? 16'sh7FFF : 16'sh8001);
  endfunction
  // ==========================================================
  // Checks, bus cycles, operand passes
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic flush();
    repeat (20) CPU.cycle(1'b0, 1'b0, 2'h0, 32'h0, 1'b0);
    check(32'(got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < got.size()) check(got[i], exp_q[i]);
    total += got.size();
    got = {};
    exp_q = {};
  endtask
  task automatic pass(input logic [31:0] ctl, input int n, input logic rnd);
    rfft_cplx_s x[$];
    rfft_cplx_s y[4];
    rfft_cplx_s v;
    logic [31:0] rv;
    logic       ok;
    logic       st;
    logic       u;
    int         s;
    s = ctl[11:8];
    u = ctl[CTRL_UNSC];
    ahb(1'b1, CTRL_OFF, ctl, rv);
    for (int i = 0; i < n; i++) begin
      v = $random(seed);
      ok = rnd ? ($random(seed) % 4 != 0) : 1'b1;
      st = rnd ? ($random(seed) % 5 == 0) : 1'b0;
      CPU.cycle(1'b1, ok, 2'(i), v, st);
      if (ok && !st) x.push_back(v);
    end
    CPU.cycle(1'b0, 1'b0, 2'h0, v, 1'b0);
    if (ctl[7:4] < 3 || ctl[7:4] > 10 || s + (ctl[CTRL_DBL] ? 2 : 1) > ctl[7:4]) x = {};
    for (int b = 0; b + 1 < x.size() && !ctl[CTRL_DBL]; b += 2) begin
      v = tw(((b / 2) % (1 << s)) * (512 >> s), ctl[CTRL_IFFT]);
      exp_q.push_back(bf(x[b], x[b+1], v, u, 1'b0));
      exp_q.push_back(bf(x[b], x[b+1], v, u, 1'b1));
    end
    for (int b = 0; b + 3 < x.size() && ctl[CTRL_DBL]; b += 4) begin
      v = tw(0, ctl[CTRL_IFFT]);
      y[0] = bf(x[b], x[b+1], v, u, 1'b0);
      y[1] = bf(x[b], x[b+1], v, u, 1'b1);
      y[2] = bf(x[b+2], x[b+3], v, u, 1'b0);
      y[3] = bf(x[b+2], x[b+3], v, u, 1'b1);
      exp_q.push_back(bf(y[0], y[2], v, u, 1'b0));
      exp_q.push_back(bf(y[0], y[2], v, u, 1'b1));
      v = tw(256, ctl[CTRL_IFFT]);
      exp_q.push_back(bf(y[1], y[3], v, u, 1'b0));
      exp_q.push_back(bf(y[1], y[3], v, u, 1'b1));
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, CTRL_OFF, 32'h0, rd);
    check(rd, 32'h000000A0);
    ahb(1'b0, STAT_OFF, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b1, 8'h08, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h08, 32'h0, rd);
    check(rd, 32'h0);
    pass(32'h00000030, 40, 1'b1);
    flush();
    for (int m = 0; m < 4; m++) pass(32'h00000130 | m, 4, 1'b0);
    flush();
    pass(32'h00000034, 8, 1'b0);
    flush();
    pass(32'h00000036, 8, 1'b0);
    flush();
    pass(32'h00000230, 2, 1'b0);
    flush();
    pass(32'h00000020, 4, 1'b0);
    pass(32'h00000234, 4, 1'b0);
    pass(32'h000000B0, 4, 1'b0);
    flush();
    ahb(1'b0, CTRL_OFF, 32'h0, rd);
    check(rd, 32'h000000B0);
    ahb(1'b0, STAT_OFF, 32'h0, rd);
    check(rd, {total[15:0], 16'h0002});
    print_verdict();
  end
endmodule
